// *** hdl/ppm_top.sv ***
// power protection monitor: four trip functions behind an AXI4-Lite slave
//
// Overview of operation
// [RULE1] overpower warning raised at once
// [RULE2] overpower fault after continuous timeout
// [RULE3] power levels in percent, default 150
// [RULE4] power timeout in seconds, default 60
// [RULE5] active only in run with module
// [RULE6] separate warning and fault enables, off
// [RULE7] five percent hysteresis before clearing
// [RULE8] count faults per function
// [RULE9] timer gates fault only, not warning
// [RULE10] under pf warning raised at once
// [RULE11] under pf fault after continuous timeout
// [RULE12] over pf warning raised at once
// [RULE13] over pf fault after continuous timeout
// [RULE14] pf levels in hundredths, defaults 0.60/0.90
// [RULE15] pf timeout in tenths, default 10; the code resets it to 100 tenths
// [RULE16] underpower warning immediate, fault delayed
// [RULE17] underpower defaults 20, 30 percent, 60 s
// [RULE18] timer restarts when condition clears
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module ppm_top #(
  parameter int unsigned TENTH_CYCLES = ppm_pkg::TENTH_CYCLES
) (
  // clock, reset and freeze
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // motor state and measurement
  input wire logic run_i,
  input wire logic exp_attached_i,
  input wire logic [ppm_pkg::VAL_W-1:0] power_pct_i,
  input wire logic [6:0] pf_hund_i,
  // protection outputs
  output logic [ppm_pkg::NCH-1:0] warn_o,
  output logic [ppm_pkg::NCH-1:0] fault_o,
  output logic irq_o,
  // axi4-lite write
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ppm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ppm_pkg::ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  localparam int unsigned N = ppm_pkg::NCH;
  localparam int unsigned FL = ppm_pkg::F_FAULT_LSB;
  localparam int unsigned VW = ppm_pkg::VAL_W;
  localparam logic [ppm_pkg::TICK_W-1:0] TICK_LAST = ppm_pkg::TICK_W'(TENTH_CYCLES - 1);
  // ****************************************
  // state
  // ****************************************
  logic attached;
  logic active;
  logic tick;
  logic [ppm_pkg::TICK_W-1:0] tick_cnt;
  logic [N-1:0] warn_en, fault_en, trip, warn_q;
  logic [2*N-1:0] status, mask, events;
  ppm_pkg::ppm_cfg_t cfg [N];
  ppm_pkg::ppm_cfg_t chan_cfg [N];
  logic [ppm_pkg::CNT_W-1:0] count [N];
  logic [VW-1:0] pf_val;
  logic aw_held, w_held;
  logic [ppm_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, rd_fire;
  logic [31:0] next_rdata;
  logic rd_ok;
  logic [31:0] ctrl_img, lvl_img, tmo_img;
  logic [3:0] wr_grp, rd_grp;
  logic [1:0] wr_idx, rd_idx;
  logic [2*N-1:0] stat_clr;
  // byte lanes of a write merged over the old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction : merge
  // ****************************************
  // run gate and time base
  // ****************************************
  // the module presence line is a pin, so it is cleaned first
  ppm_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(exp_attached_i),
    .level_o(attached)
  );
  // protections live only in run with the module present
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) active <= 1'b0;
    else if (ce_i) active <= run_i && attached; // [RULE5]
  end
  // one pulse per tenth of a second drives every fault timer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (ce_i) begin
      tick <= tick_cnt == TICK_LAST;
      if (tick_cnt == TICK_LAST) tick_cnt <= '0;
      else tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign pf_val = VW'(pf_hund_i);
  // ****************************************
  // protection channels
  // ****************************************
  for (genvar i = 0; i < N; i++) begin : g_ch
    // power timeouts are held in seconds, scaled here to tenths
    always_comb begin
      chan_cfg[i] = cfg[i];
      if (!ppm_pkg::PF_MASK[i]) begin
        chan_cfg[i].timeout = ppm_pkg::TMR_W'(cfg[i].timeout * ppm_pkg::SEC_TENTHS); // [RULE4]
      end
    end
    ppm_chan #(
      .OVER(ppm_pkg::OVER_MASK[i])
    ) u_ch (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .active_i(active),
      .warn_en_i(warn_en[i]),
      .fault_en_i(fault_en[i]),
      .tick_i(tick),
      .cfg_i(chan_cfg[i]),
      .value_i(ppm_pkg::PF_MASK[i] ? pf_val : power_pct_i),
      .warn_o(warn_o[i]),
      .fault_o(fault_o[i]),
      .trip_o(trip[i]),
      .count_o(count[i])
    );
  end
  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // address and data are taken in either order, one write at a time
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_grp = aw_addr[7:4];
  assign wr_idx = aw_addr[3:2];
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= ppm_pkg::RESP_OKAY;
    end else if (ce_i) begin
      s_axi_awready_o <= !aw_held && !s_axi_awready_o && !s_axi_bvalid_o;
      s_axi_wready_o <= !w_held && !s_axi_wready_o && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_grp == ppm_pkg::G_LVL || wr_grp == ppm_pkg::G_TMO ||
                          (wr_grp == ppm_pkg::G_MISC && aw_addr != ppm_pkg::A_LIVE)) ?
                         ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) s_axi_bvalid_o <= 1'b0;
    end
  end
  // ****************************************
  // configuration registers
  // ****************************************
  // write images per target, each with its own driver, merged per byte lane
  assign ctrl_img = merge({24'h00_0000, fault_en, warn_en}, w_data, w_strb);
  assign lvl_img = merge({6'h00, cfg[wr_idx].fault_lvl, 6'h00, cfg[wr_idx].warn_lvl},
                         w_data, w_strb);
  assign tmo_img = merge({22'h00_0000, cfg[wr_idx].timeout}, w_data, w_strb);
  // enables and mask; every enable starts cleared
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      warn_en <= '0; // [RULE6]
      fault_en <= '0; // [RULE6]
      mask <= '0;
    end else if (ce_i && wr_fire) begin
      if (aw_addr == ppm_pkg::A_CTRL) begin
        warn_en <= ctrl_img[N-1:0];
        fault_en <= ctrl_img[2*N-1:N];
      end
      if (aw_addr == ppm_pkg::A_MASK) mask <= w_data[2*N-1:0] & {2*N{w_strb[0]}};
    end
  end
  // thresholds and timeouts with their factory settings
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg[0] <= '{ppm_pkg::DEF_OVP_LVL, ppm_pkg::DEF_OVP_LVL, ppm_pkg::DEF_PWR_TMO}; // [RULE3]
      cfg[1] <= '{ppm_pkg::DEF_UNP_WARN, ppm_pkg::DEF_UNP_FAULT, ppm_pkg::DEF_PWR_TMO}; // [RULE17]
      cfg[2] <= '{ppm_pkg::DEF_UPF_LVL, ppm_pkg::DEF_UPF_LVL, ppm_pkg::DEF_PF_TMO}; // [RULE14]
      cfg[3] <= '{ppm_pkg::DEF_OPF_LVL, ppm_pkg::DEF_OPF_LVL, ppm_pkg::DEF_PF_TMO}; // [RULE15]
    end else if (ce_i && wr_fire) begin
      if (wr_grp == ppm_pkg::G_LVL) begin
        cfg[wr_idx].warn_lvl <= lvl_img[VW-1:0];
        cfg[wr_idx].fault_lvl <= lvl_img[FL +: VW];
      end
      if (wr_grp == ppm_pkg::G_TMO) begin
        cfg[wr_idx].timeout <= tmo_img[ppm_pkg::TMR_W-1:0];
      end
    end
  end
  // ****************************************
  // events and interrupt
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) warn_q <= '0;
    else if (ce_i) warn_q <= warn_o;
  end
  assign events = {trip, warn_o & ~warn_q};
  assign stat_clr = (wr_fire && aw_addr == ppm_pkg::A_STAT && w_strb[0]) ?
                    w_data[2*N-1:0] : '0;
  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) status <= '0;
    else if (ce_i) status <= (status & ~stat_clr) | events;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) irq_o <= 1'b0;
    else if (ce_i) irq_o <= |(status & mask);
  end
  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign rd_grp = s_axi_araddr_i[7:4];
  assign rd_idx = s_axi_araddr_i[3:2];
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  // read image; unmapped words answer zero with an error
  always_comb begin
    next_rdata = '0;
    rd_ok = 1'b1;
    case (rd_grp)
      ppm_pkg::G_MISC: begin
        case (s_axi_araddr_i[3:0])
          ppm_pkg::A_CTRL[3:0]: next_rdata[2*N-1:0] = {fault_en, warn_en};
          ppm_pkg::A_STAT[3:0]: next_rdata[2*N-1:0] = status;
          ppm_pkg::A_MASK[3:0]: next_rdata[2*N-1:0] = mask;
          ppm_pkg::A_LIVE[3:0]: begin
            next_rdata[2*N-1:0] = {fault_o, warn_o};
            next_rdata[ppm_pkg::F_ACT_BIT] = active;
          end
          default: rd_ok = 1'b0;
        endcase
      end
      ppm_pkg::G_LVL: begin
        next_rdata[VW-1:0] = cfg[rd_idx].warn_lvl;
        next_rdata[FL +: VW] = cfg[rd_idx].fault_lvl;
      end
      ppm_pkg::G_TMO: next_rdata[ppm_pkg::TMR_W-1:0] = cfg[rd_idx].timeout;
      ppm_pkg::G_CNT: next_rdata[ppm_pkg::CNT_W-1:0] = count[rd_idx];
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= ppm_pkg::RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o;
      if (rd_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= next_rdata;
        s_axi_rresp_o <= rd_ok ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) s_axi_rvalid_o <= 1'b0;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  AST_OVP_WARN_NOW: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE1]
    ce_i && active && warn_en[0] && power_pct_i > cfg[0].warn_lvl |=> warn_o[0])
    else $error("overpower warning did not follow its threshold");
  AST_UNP_WARN_NOW: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE16]
    ce_i && active && warn_en[1] && power_pct_i < cfg[1].warn_lvl |=> warn_o[1])
    else $error("underpower warning did not follow its threshold");
  AST_UPF_WARN_NOW: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE10]
    ce_i && active && warn_en[2] && pf_val < cfg[2].warn_lvl |=> warn_o[2])
    else $error("under pf warning did not follow its threshold");
  AST_OPF_WARN_NOW: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE12]
    ce_i && active && warn_en[3] && pf_val > cfg[3].warn_lvl |=> warn_o[3])
    else $error("over pf warning did not follow its threshold");
  AST_OVP_HYST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE7]
    ce_i && warn_o[0] && active && warn_en[0] && power_pct_i == cfg[0].warn_lvl
    && cfg[0].warn_lvl != '0 |=> warn_o[0])
    else $error("overpower warning cleared inside the band");
  AST_TICK_PERIOD: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE15]
    tick && ce_i |=> !tick)
    else $error("tenth pulse lasted more than one cycle");
  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && |(status & mask) |=> irq_o)
    else $error("interrupt missing for a pending event");
endmodule : ppm_top

// *** hdl/ppm_pkg.sv ***
// shared constants, types and register map of the power protection monitor
package ppm_pkg;
  // ****************************************
  // widths and channel layout
  // ****************************************
  localparam int unsigned NCH = 4;
  localparam int unsigned VAL_W = 10;
  localparam int unsigned TMR_W = 10;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned MUL_W = 18;
  localparam int unsigned TICK_W = 21;
  localparam int unsigned ADDR_W = 8;
  localparam logic [3:0] OVER_MASK = 4'h9; // overpower and over pf trip upward
  localparam logic [3:0] PF_MASK = 4'hC; // pf channels keep timeout in tenths
  // ****************************************
  // factory settings
  // ****************************************
  localparam logic [VAL_W-1:0] DEF_OVP_LVL = 10'h096;
  localparam logic [VAL_W-1:0] DEF_UNP_WARN = 10'h01E;
  localparam logic [VAL_W-1:0] DEF_UNP_FAULT = 10'h014;
  localparam logic [VAL_W-1:0] DEF_UPF_LVL = 10'h03C;
  localparam logic [VAL_W-1:0] DEF_OPF_LVL = 10'h05A;
  localparam logic [TMR_W-1:0] DEF_PWR_TMO = 10'h03C;
  localparam logic [TMR_W-1:0] DEF_PF_TMO = 10'h064;
  localparam logic [TMR_W-1:0] SEC_TENTHS = 10'h00A;
  // ****************************************
  // hysteresis and time base
  // ****************************************
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] HYST_LO = 7'h5F;
  localparam logic [6:0] HYST_HI = 7'h69;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TENTH_NS = 100_000_000;
  localparam int unsigned TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] A_LIVE = 8'h0C;
  localparam logic [3:0] G_MISC = 4'h0;
  localparam logic [3:0] G_LVL = 4'h1;
  localparam logic [3:0] G_TMO = 4'h2;
  localparam logic [3:0] G_CNT = 4'h3;
  localparam int unsigned F_FAULT_LSB = 16;
  localparam int unsigned F_ACT_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [VAL_W-1:0] warn_lvl;
    logic [VAL_W-1:0] fault_lvl;
    logic [TMR_W-1:0] timeout;
  } ppm_cfg_t;
  typedef enum logic [1:0] {ST_CLEAR, ST_TIMING, ST_TRIPPED} ppm_fst_t;
endpackage : ppm_pkg

// *** hdl/ppm_sync.sv ***
// three-stage pin synchroniser that accepts a level once two stages agree
`timescale 1ns/10ps
module ppm_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  logic meta;
  logic s2;
  logic s3;
  // meta is read only by s2; the level moves when s2 and s3 agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      meta <= pin_i;
      s2 <= meta;
      s3 <= s2;
      if (s2 == s3) level_o <= s3;
    end
  end
endmodule : ppm_sync

// *** hdl/ppm_chan.sv ***
// one protection function: warning, delayed fault and fault count
`timescale 1ns/10ps
module ppm_chan #(
  parameter bit OVER = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control
  input wire logic active_i,
  input wire logic warn_en_i,
  input wire logic fault_en_i,
  input wire logic tick_i,
  input wire ppm_pkg::ppm_cfg_t cfg_i,
  input wire logic [ppm_pkg::VAL_W-1:0] value_i,
  // results
  output logic warn_o,
  output logic fault_o,
  output logic trip_o,
  output logic [ppm_pkg::CNT_W-1:0] count_o
);
  typedef logic [ppm_pkg::MUL_W-1:0] mul_t;
  ppm_pkg::ppm_fst_t st;
  logic cond_f;
  logic [ppm_pkg::TMR_W-1:0] tmr;
  logic w_set, w_clr, f_set, f_clr;
  mul_t v100;
  // compare with a 5 % band; scaled by 100 so no divider is needed
  always_comb begin
    v100 = mul_t'(value_i) * mul_t'(ppm_pkg::PCT_FULL);
    if (OVER) begin
      w_set = value_i > cfg_i.warn_lvl;
      w_clr = v100 < mul_t'(cfg_i.warn_lvl) * mul_t'(ppm_pkg::HYST_LO);
      f_set = value_i > cfg_i.fault_lvl;
      f_clr = v100 < mul_t'(cfg_i.fault_lvl) * mul_t'(ppm_pkg::HYST_LO);
    end else begin
      w_set = value_i < cfg_i.warn_lvl;
      w_clr = v100 > mul_t'(cfg_i.warn_lvl) * mul_t'(ppm_pkg::HYST_HI);
      f_set = value_i < cfg_i.fault_lvl;
      f_clr = v100 > mul_t'(cfg_i.fault_lvl) * mul_t'(ppm_pkg::HYST_HI);
    end
  end
  // warning follows the threshold at once, no timer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) warn_o <= 1'b0;
    else if (ce_i) begin
      if (!active_i || !warn_en_i) warn_o <= 1'b0; // [RULE5] [RULE6]
      else if (w_set) warn_o <= 1'b1; // [RULE1] [RULE10] [RULE12] [RULE16]
      else if (w_clr) warn_o <= 1'b0; // [RULE7]
    end
  end
  // fault condition latch with the same band
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cond_f <= 1'b0;
    else if (ce_i) begin
      if (!active_i || !fault_en_i) cond_f <= 1'b0; // [RULE5] [RULE6]
      else if (f_set) cond_f <= 1'b1;
      else if (f_clr) cond_f <= 1'b0; // [RULE7]
    end
  end
  // delay timer in tenths; only the fault output waits on it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= ppm_pkg::ST_CLEAR;
      tmr <= '0;
      fault_o <= 1'b0;
      trip_o <= 1'b0;
    end else if (ce_i) begin
      trip_o <= 1'b0;
      case (st)
        ppm_pkg::ST_CLEAR: begin
          tmr <= '0;
          if (cond_f) st <= ppm_pkg::ST_TIMING;
        end
        ppm_pkg::ST_TIMING: begin
          if (!cond_f) begin
            st <= ppm_pkg::ST_CLEAR; // [RULE18]
            tmr <= '0;
          end else if (tmr >= cfg_i.timeout) begin
            st <= ppm_pkg::ST_TRIPPED; // [RULE2] [RULE9] [RULE11] [RULE13]
            fault_o <= 1'b1;
            trip_o <= 1'b1;
          end else if (tick_i) tmr <= tmr + 1'b1;
        end
        ppm_pkg::ST_TRIPPED: begin
          if (!cond_f) begin
            st <= ppm_pkg::ST_CLEAR;
            fault_o <= 1'b0;
            tmr <= '0;
          end
        end
        default: st <= ppm_pkg::ST_CLEAR;
      endcase
    end
  end
  // fault statistic, wraps at full scale
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) count_o <= '0;
    else if (ce_i && trip_o) count_o <= count_o + 1'b1; // [RULE8]
  end
  AST_INACTIVE_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE5]
    ce_i && !active_i |=> !warn_o && !cond_f ##1 !fault_o && tmr == '0)
    else $error("protection stayed live while inactive");
  AST_TRIP_NEEDS_TIMER: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE9]
    $rose(fault_o) |-> $past(tmr) >= $past(cfg_i.timeout) && $past(cond_f))
    else $error("fault rose before the timer expired");
  AST_TIMER_RESTART: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE18]
    ce_i && st == ppm_pkg::ST_TIMING && !cond_f |=> tmr == '0 && !fault_o)
    else $error("timer kept its count after the condition left");
  AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE8]
    ce_i && trip_o |=> count_o == $past(count_o) + 1'b1)
    else $error("fault count did not step on a trip");
  AST_FAULT_ENABLE: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE6]
    ce_i && !fault_en_i ##1 ce_i |=> !fault_o)
    else $error("fault raised while its enable was off");
endmodule : ppm_chan

// *** dv/ppm_meas_model.sv ***
// expansion module model feeding power and power factor
`timescale 1ns/10ps
module ppm_meas_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // wanted readings
  input wire logic plug_i,
  input wire logic [9:0] pwr_i,
  input wire logic [6:0] pf_i,
  // module pins
  output logic attached_o,
  output logic [9:0] power_pct_o,
  output logic [6:0] pf_hund_o
);
  // readings lag one clock; when unplugged the lines float and toggle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      attached_o <= 1'b0;
      power_pct_o <= 10'h000;
      pf_hund_o <= 7'h00;
    end else begin
      attached_o <= plug_i;
      power_pct_o <= plug_i ? pwr_i : ~power_pct_o;
      pf_hund_o <= plug_i ? pf_i : ~pf_hund_o;
    end
  end
endmodule : ppm_meas_model

// *** dv/ppm_top_tb.sv ***
// self-checking bench of the power protection monitor
`timescale 1ns/10ps
module ppm_top_tb;
  // ****
  // signals
  // ****
  // bready and rready stay high, so back-to-back calls never toggle them in one step
  logic clk_i = 0, nrst = 0, rn = 0, plug = 0, awv = 0, wv = 0, bry = 1, arv = 0, rry = 1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdt, seed = 32'h0000_fc3e;
  logic [9:0] pw = 10'h064, pwr;
  logic [6:0] pf = 7'h4B, pfh;
  logic [6:0] cor [6] = '{7'h3B, 7'h3F, 7'h40, 7'h5B, 7'h56, 7'h55};
  logic [3:0] warn, fault, wexp = 4'h0;
  logic att, irq, awr, wrd, bv, arv_r, rv;
  logic [1:0] br, rr;
  int failures = 0, num_checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  ppm_meas_model u_ppm_meas_model (.clk_i(clk_i), .nrst_i(nrst), .plug_i(plug), .pwr_i(pw),
    .pf_i(pf), .attached_o(att), .power_pct_o(pwr), .pf_hund_o(pfh));
  ppm_top #(.TENTH_CYCLES(20)) u_ppm_top (.clk_i(clk_i), .nrst_i(nrst), .ce_i(1'b1),
    .run_i(rn), .exp_attached_i(att), .power_pct_i(pwr), .pf_hund_i(pfh), .warn_o(warn),
    .fault_o(fault), .irq_o(irq), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arv_r), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected warning with the release band applied
  function automatic logic hy(input bit over, input int v, input int l, input logic w);
    if (over) return (v > l) ? 1'b1 : (100 * v < 95 * l) ? 1'b0 : w;
    return (v < l) ? 1'b1 : (100 * v > 105 * l) ? 1'b0 : w;
  endfunction : hy
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    chk({30'h0, br}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1;
    do @(posedge clk_i); while (!arv_r);
    arv <= 0;
    do @(posedge clk_i); while (!rv);
    chk(rdt, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // poll a fault bit for a bounded time; the poll cannot hang the run
  task automatic fw(input int i);
    for (int k = 0; k < 60 && !fault[i]; k++) @(posedge clk_i);
    chk({31'h0, fault[i]}, 32'h0000_0001);
  endtask : fw
  // cut a hang short well past the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    wt(10);
    nrst <= 1;
    wt(1);
    rd(8'h00, 32'h0000_0000, 2'h0);
    rd(8'h10, 32'h0096_0096, 2'h0);
    rd(8'h14, 32'h0014_001E, 2'h0);
    rd(8'h18, 32'h003C_003C, 2'h0);
    rd(8'h1C, 32'h005A_005A, 2'h0);
    rd(8'h24, 32'h0000_003C, 2'h0);
    rd(8'h2C, 32'h0000_0064, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h30, 32'h0000_0001, 2'h2);
    $display("defaults test ended");
    wr(8'h00, 32'h0000_00FF, 2'h0);
    wr(8'h20, 32'h0000_0001, 2'h0);
    wr(8'h28, 32'h0000_0002, 2'h0);
    wr(8'h2C, 32'h0000_0002, 2'h0);
    rn <= 1;
    plug <= 1;
    wt(12);
    pw <= 10'h0A0;
    wt(3);
    chk({fault, warn}, 32'h0000_0001);
    wt(100);
    pw <= 10'h064;
    wt(4);
    pw <= 10'h0A0;
    wt(165);
    chk({31'h0, fault[0]}, 32'h0000_0000);
    fw(0);
    rd(8'h30, 32'h0000_0001, 2'h0);
    rd(8'h04, 32'h0000_0011, 2'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'h08, 32'h0000_0011, 2'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(8'h04, 32'h0000_0011, 2'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0000_0000);
    pw <= 10'h08F;
    wt(3);
    chk({fault, warn}, 32'h0000_0011);
    pw <= 10'h08E;
    wt(4);
    chk({fault, warn}, 32'h0000_0000);
    pw <= 10'h019;
    wt(3);
    chk({28'h0, warn}, 32'h0000_0002);
    pw <= 10'h064;
    $display("power test ended");
    // corner values first, then random power factors
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      pf <= (i < 6) ? cor[i] : 7'(seed % 101);
      wt(3);
      wexp[2] = hy(0, int'(pf), 60, wexp[2]);
      wexp[3] = hy(1, int'(pf), 90, wexp[3]);
      chk({30'h0, warn[3:2]}, {30'h0, wexp[3:2]});
    end
    for (int k = 2; k < 4; k++) begin
      pf <= 7'h4B;
      wt(5);
      pf <= (k == 2) ? 7'h32 : 7'h5F;
      wt(15);
      chk({31'h0, fault[k]}, 32'h0000_0000);
      fw(k);
    end
    pw <= 10'h0C8;
    wt(3);
    rn <= 0;
    wt(4);
    chk({fault, warn}, 32'h0000_0000);
    $display("pf and run test ended");
    test_done();
  end
endmodule : ppm_top_tb
